// file: design/sleep_timer_regs.svh
`ifndef SLEEP_TIMER_REGS_SVH
`define SLEEP_TIMER_REGS_SVH

// How it works
// - Counter is 24 bits and steps by one on each rising low-frequency clock edge.
// - Counter runs from reset release onward; nothing stops, clears or reloads it.
// - Compare event fires when all 24 counter bits equal all 24 compare bits.
// - Each compare event sets the sleep compare flag, interrupt source 5.
// - Interrupt request is set one clock after enable bit and sleep compare flag are both set, and clears one clock after either clears.
// - Counter keeps running in light and deep sleep; compare event wakes to active.
// - Compare value resets to 0xFFFFF and holds it until software writes.
// - Each compare event is also given as DMA trigger 9.
// - Reading the high byte register returns counter bits 23 to 16.
// - High byte read shows the value captured when the low byte was read.
// - Writing the high byte stages compare bits 23 to 16; counter untouched.
// - Staged high compare byte applies only when the low byte is written.
// - Middle byte reads captured counter bits 15 to 8; writes stage compare bits.
// - Low byte read returns bits 7 to 0 and captures upper bytes; write commits.

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SLP_LOW_OFF  8'h95
`define SLP_MID_OFF  8'h96
`define SLP_HIGH_OFF 8'h97

// ----------------------------------------------------------------------------
// Reset values and identities
// ----------------------------------------------------------------------------
`define SLP_CMP_RST   24'h0f_ffff
`define SLP_CNT_RST   24'h00_0000
`define SLP_BYTE_RST  8'h00
`define SLP_CNT_ONE   24'h00_0001
`define SLP_IRQ_SRC   5
`define SLP_DMA_TRIG  9

`endif

// file: design/sleep_timer_pkg.sv
`default_nettype none

package sleep_timer_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [7:0]  sfr_addr_t;
    typedef logic [23:0] count_t;
    typedef logic [15:0] upper_t;

    // Power mode reported by the power manager, one-hot.
    typedef enum logic [2:0] {
        active_power_mode = 3'h1,
        light_sleep_mode  = 3'h2,
        deep_sleep_mode   = 3'h4
    } pwr_mode_t;
endpackage

`default_nettype wire

// file: design/lf_tick_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Low-frequency clock synchroniser and rising-edge tick
// ----------------------------------------------------------------------------
module lf_tick_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic lf_clk_in,
    output logic      lf_tick
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    logic tick_r;
    logic tick_nxt;

    // Only the second stage and later look at the slow clock level.
    always_comb begin
        tick_nxt = sync_r && !last_r;
    end

    // Two stages guard against metastability; the third remembers the old level.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            meta_r <= lf_clk_in;
            sync_r <= meta_r;
            last_r <= sync_r;
            tick_r <= tick_nxt;
        end
    end

    assign lf_tick = tick_r;
endmodule

`default_nettype wire

// file: design/sleep_wakeup_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sleep_timer_regs.svh"

module sleep_wakeup_timer (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       lf_clk_in,
    input  wire sleep_timer_pkg::sfr_addr_t sfr_addr,
    input  wire sleep_timer_pkg::byte_t     sfr_wdata,
    input  wire logic                       sfr_wr,
    input  wire logic                       sfr_rd,
    output sleep_timer_pkg::byte_t          sfr_rdata,
    input  wire logic                       sleep_compare_irq_enable,
    input  wire logic                       flag_clear,
    input  wire sleep_timer_pkg::pwr_mode_t power_mode,
    output logic                            sleep_compare_flag,
    output logic                            irq_req,
    output logic                            dma_trigger,
    output logic                            wake_req
);
    import sleep_timer_pkg::*;

    logic   lf_tick;
    logic   tick_d_r;
    logic   tick_d_nxt;
    count_t count_r;
    count_t count_nxt;
    count_t cmp_r;
    count_t cmp_nxt;
    upper_t stage_r;
    upper_t stage_nxt;
    upper_t snap_r;
    upper_t snap_nxt;
    byte_t  rdata_r;
    byte_t  rdata_nxt;
    logic   evt;
    logic   sleeping;
    logic   flag_r;
    logic   flag_nxt;
    logic   irq_r;
    logic   irq_nxt;
    logic   dma_r;
    logic   dma_nxt;
    logic   wake_r;
    logic   wake_nxt;

    // Address decode shared by the read and write paths.
    function automatic logic hit(input sfr_addr_t a, input sfr_addr_t off);
        return a == off;
    endfunction

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    lf_tick_sync lf_tick_sync_i (
        .clk       (clk),
        .rst_b     (rst_b),
        .lf_clk_in (lf_clk_in),
        .lf_tick   (lf_tick)
    );

    // The counter steps on every rising slow edge and has no other load path.
    always_comb begin
        count_nxt = count_r;
        if (lf_tick) begin
            count_nxt = count_r + `SLP_CNT_ONE;
        end
        tick_d_nxt = lf_tick;
    end

    // Registers the counter and the delayed tick used for comparing.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_r  <= `SLP_CNT_RST;
            tick_d_r <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            tick_d_r <= tick_d_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Compare value and staging
    // ------------------------------------------------------------------------
    // Upper bytes are staged and land together with the low byte write.
    always_comb begin
        cmp_nxt   = cmp_r;
        stage_nxt = stage_r;
        if (sfr_wr && hit(sfr_addr, `SLP_HIGH_OFF)) begin
            stage_nxt[15:8] = sfr_wdata;
        end
        if (sfr_wr && hit(sfr_addr, `SLP_MID_OFF)) begin
            stage_nxt[7:0] = sfr_wdata;
        end
        if (sfr_wr && hit(sfr_addr, `SLP_LOW_OFF)) begin
            cmp_nxt = {stage_r, sfr_wdata};
        end
    end

    // Registers the compare value and the staged upper bytes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmp_r   <= `SLP_CMP_RST;
            stage_r <= 16'h0000;
        end else begin
            cmp_r   <= cmp_nxt;
            stage_r <= stage_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Read path and snapshot
    // ------------------------------------------------------------------------
    // A low byte read returns live bits and freezes the upper bytes.
    always_comb begin
        snap_nxt  = snap_r;
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            if (hit(sfr_addr, `SLP_LOW_OFF)) begin
                rdata_nxt = count_r[7:0];
                snap_nxt  = count_r[23:8];
            end else if (hit(sfr_addr, `SLP_MID_OFF)) begin
                rdata_nxt = snap_r[7:0];
            end else if (hit(sfr_addr, `SLP_HIGH_OFF)) begin
                rdata_nxt = snap_r[15:8];
            end else begin
                rdata_nxt = `SLP_BYTE_RST;
            end
        end
    end

    // Registers the snapshot and the read data.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            snap_r  <= 16'h0000;
            rdata_r <= `SLP_BYTE_RST;
        end else begin
            snap_r  <= snap_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Events, flag, interrupt, DMA and wake
    // ------------------------------------------------------------------------
    // Match is checked once per counter value, the cycle after it changes.
    always_comb begin
        evt = tick_d_r && (count_r == cmp_r);
        case (power_mode)
            light_sleep_mode: sleeping = 1'b1;
            deep_sleep_mode: sleeping = 1'b1;
            active_power_mode: sleeping = 1'b0;
            default: sleeping = 1'b0;
        endcase
        flag_nxt = evt || (flag_r && !flag_clear);
        irq_nxt  = flag_r && sleep_compare_irq_enable;
        dma_nxt  = evt;
        wake_nxt = evt && sleeping;
    end

    // Registers every event output.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
            irq_r  <= 1'b0;
            dma_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            irq_r  <= irq_nxt;
            dma_r  <= dma_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign sfr_rdata          = rdata_r;
    assign sleep_compare_flag = flag_r;
    assign irq_req            = irq_r;
    assign dma_trigger        = dma_r;
    assign wake_req           = wake_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_low;
        sfr_wr && hit(sfr_addr, `SLP_LOW_OFF);
    endsequence

    sequence s_rd_low;
        sfr_rd && hit(sfr_addr, `SLP_LOW_OFF);
    endsequence

    sequence s_rd_high;
        sfr_rd && hit(sfr_addr, `SLP_HIGH_OFF);
    endsequence

    AST_INC: assert property (lf_tick |=> count_r == $past(count_r) + `SLP_CNT_ONE)
        else $error("Counter did not step on a slow tick.");
    AST_RUN: assert property (!lf_tick |=> $stable(count_r))
        else $error("Counter moved without a slow tick.");
    AST_MATCH: assert property (tick_d_r && count_r == cmp_r |=> dma_trigger && flag_r)
        else $error("Match did not raise trigger and flag.");
    AST_FLAG: assert property (flag_r && !flag_clear |=> flag_r)
        else $error("Flag dropped without a clear.");
    AST_IRQ: assert property (irq_req == $past(flag_r && sleep_compare_irq_enable))
        else $error("Interrupt request without flag and enable.");
    AST_WAKE: assert property (dma_trigger && $past(sleeping) |-> wake_req)
        else $error("Match in sleep did not wake.");
    AST_DMA: assert property (dma_trigger |=> !dma_trigger)
        else $error("Trigger longer than one cycle.");
    AST_SNAP: assert property (s_rd_low |=> snap_r == $past(count_r[23:8]))
        else $error("Low byte read did not capture the upper bytes.");
    AST_RDHI: assert property (s_rd_high |=> sfr_rdata == $past(snap_r[15:8]))
        else $error("High byte read not the captured value.");
    AST_STAGE: assert property (!(sfr_wr && hit(sfr_addr, `SLP_LOW_OFF))
        |=> $stable(cmp_r))
        else $error("Compare changed without a low byte write.");
    // Reset itself is watched here, so this one check is never disabled.
    AST_CMPRST: assert property (disable iff (1'b0) !rst_b |=> cmp_r == `SLP_CMP_RST)
        else $error("Compare value not at its reset default.");
    AST_COMMIT: assert property (s_wr_low |=> cmp_r == {$past(stage_r), $past(sfr_wdata)})
        else $error("Low byte write did not commit compare.");
endmodule

`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sleep_timer_regs.svh"

module tb_top;
    import sleep_timer_pkg::*;

    // ------------------------------------------------------------------------
    // Stimulus, observed outputs and expectation queues
    // ------------------------------------------------------------------------
    logic      clk        = 1'b0;
    logic      rst_b      = 1'b0;
    logic      lf_clk_in  = 1'b0;
    sfr_addr_t sfr_addr   = '0;
    byte_t     sfr_wdata  = '0;
    logic      sfr_wr     = 1'b0;
    logic      sfr_rd     = 1'b0;
    logic      irq_en     = 1'b0;
    logic      flag_clear = 1'b0;
    pwr_mode_t power_mode = active_power_mode;
    byte_t     sfr_rdata;
    logic      flag;
    logic      irq_req;
    logic      dma_trigger;
    logic      wake_req;
    logic      rd_d       = 1'b0;
    count_t    cnt        = '0;
    count_t    snap;
    count_t    tgt;
    byte_t     rd_q[$];
    logic      ev_q[$];
    int        fail_count   = 0;
    int        total_checks = 0;
    pwr_mode_t modes[3]     = '{active_power_mode, light_sleep_mode, deep_sleep_mode};

    // The system clock toggles every half period of 5 ns.
    always #5 clk = ~clk;

    sleep_wakeup_timer sleep_wakeup_timer_i (
        .clk                      (clk),
        .rst_b                    (rst_b),
        .lf_clk_in                (lf_clk_in),
        .sfr_addr                 (sfr_addr),
        .sfr_wdata                (sfr_wdata),
        .sfr_wr                   (sfr_wr),
        .sfr_rd                   (sfr_rd),
        .sfr_rdata                (sfr_rdata),
        .sleep_compare_irq_enable (irq_en),
        .flag_clear               (flag_clear),
        .power_mode               (power_mode),
        .sleep_compare_flag       (flag),
        .irq_req                  (irq_req),
        .dma_trigger              (dma_trigger),
        .wake_req                 (wake_req)
    );

    // ------------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Each result that appears is paired with the oldest note; a stray one is a mismatch.
    always @(posedge clk) begin
        if (rd_d) begin
            if (rd_q.size() == 0) check(24'h1, 24'h0);
            else check(sfr_rdata, rd_q.pop_front());
        end
        if (dma_trigger === 1'b1) begin
            if (ev_q.size() == 0) check(24'h1, 24'h0);
            else begin
                check(wake_req, ev_q.pop_front());
                check(flag, 1'b1);
            end
        end
        rd_d <= sfr_rd;
    end

    // ------------------------------------------------------------------------
    // Bus and slow clock drivers; each lets an edge pass before the next access
    // ------------------------------------------------------------------------
    task automatic wr(input sfr_addr_t a, input byte_t d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input sfr_addr_t a, input byte_t exp);
        rd_q.push_back(exp);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic read_cnt();
        rd(`SLP_LOW_OFF, cnt[7:0]);
        rd(`SLP_MID_OFF, cnt[15:8]);
        rd(`SLP_HIGH_OFF, cnt[23:16]);
    endtask

    // Slow clock pulses are three system cycles high and three low.
    task automatic pulse(input int n);
        repeat (n) begin
            lf_clk_in <= 1'b1;
            repeat (3) @(posedge clk);
            lf_clk_in <= 1'b0;
            repeat (3) @(posedge clk);
            cnt = cnt + 1'b1;
        end
    endtask

    task automatic clear_flag();
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
        repeat (3) @(posedge clk);
        check(flag, 1'b0);
        check(irq_req, 1'b0);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(75135));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({flag, irq_req, dma_trigger, wake_req}, 24'h0);
        read_cnt();
        rd(8'h98, 8'h00);
        pulse(300);
        snap = cnt;
        rd(`SLP_LOW_OFF, snap[7:0]);
        pulse(300);
        rd(`SLP_MID_OFF, snap[15:8]);
        rd(`SLP_HIGH_OFF, snap[23:16]);
        read_cnt();
        tgt = cnt + 24'h00_0003;
        wr(`SLP_HIGH_OFF, tgt[23:16]);
        wr(`SLP_MID_OFF, tgt[15:8]);
        pulse(5);
        tgt = cnt + 24'h00_0003;
        wr(`SLP_LOW_OFF, tgt[7:0]);
        ev_q.push_back(1'b0);
        pulse(3);
        clear_flag();
        for (int i = 0; i < 3; i++) begin
            power_mode <= modes[i];
            irq_en <= (i != 1);
            tgt = cnt + 24'h00_0001 + 24'($urandom_range(0, 5));
            wr(`SLP_HIGH_OFF, tgt[23:16]);
            wr(`SLP_MID_OFF, tgt[15:8]);
            wr(`SLP_LOW_OFF, tgt[7:0]);
            read_cnt();
            ev_q.push_back(modes[i] != active_power_mode);
            pulse(int'(tgt - cnt));
            repeat (2) @(posedge clk);
            check(irq_req, irq_en);
            check(flag, 1'b1);
            clear_flag();
        end
        read_cnt();
        repeat (4) @(posedge clk);
        check(24'(ev_q.size()), 24'h0);
        summarize();
    end

    // A hang is cut short well past the expected run of about 38 us.
    initial begin
        #500_000;
        fail_count++;
        summarize();
    end
endmodule

`default_nettype wire
